// >>> bench/crossbar_priority_arbiter_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
// ----------------------------------------------------------------
// Self-checking bench of the crossbar arbiter.
// ----------------------------------------------------------------
module crossbar_priority_arbiter_test;
  import xbpa_pkg::*;
  localparam logic [31:0] MEM = 32'h0000_1000; // A memory address.
  localparam logic [31:0] PER = {PER_SEL_VAL, 28'h0000100}; // A peripheral.
  logic             ref_clk = 1'b0;
  logic             rst = 1'b1;
  logic [4:0]       req;
  wire [4:0]        gnt;
  logic [4:0][31:0] addr;
  logic             pwr, pen, herr, pbusy;
  logic [15:0]      pbase;
  logic [1:0]       load;
  int               bad_count = 0;
  int               total_checks = 0;

  always #4 ref_clk = ~ref_clk;

  xbpa_masters i_xbpa_masters (.ref_clk_in(ref_clk), .gnt_in(gnt), .req_out(req),
    .addr_out(addr), .page_wr_out(pwr), .page_en_out(pen), .page_base_out(pbase));
  xbpa_arbiter i_xbpa_arbiter (.ref_clk_in(ref_clk), .rst_in(rst),
    .acc_req_in(req[4]), .acc_addr_in(addr[4]), .acc_gnt_out(gnt[4]),
    .hst_req_in(req[3]), .hst_addr_in(addr[3]), .hst_gnt_out(gnt[3]),
    .hst_err_out(herr), .dp0_req_in(req[2]), .dp0_addr_in(addr[2]),
    .dp0_gnt_out(gnt[2]), .dp1_req_in(req[1]), .dp1_addr_in(addr[1]),
    .dp1_gnt_out(gnt[1]), .fetch_req_in(req[0]), .fetch_gnt_out(gnt[0]),
    .core_page_wr_in(pwr), .core_page_en_in(pen), .core_page_base_in(pbase),
    .mem_load_out(load), .per_busy_out(pbusy));

  // Inputs move 1 ns after the edge; granted requests retire on the edge.
  task step;
    @(posedge ref_clk);
    #1;
  endtask

  // Grants settle 1 ns after the requests change.
  task post(input logic [4:0] m, input logic [31:0] a);
    i_xbpa_masters.post(m, a);
    #1;
  endtask

  // Different targets at once: all four grants in one cycle.
  task t_parallel;
    i_xbpa_masters.post(5'b10000, PER);
    post(5'b00111, MEM);
    `CHK("grants", 5'b10111, gnt)
    step;
    `CHK("mem load", 2'h3, load)
    `CHK("per busy", 1'b1, pbusy)
  endtask

  // Four memory sources: the fourth waits one cycle with its request held.
  task t_mem_four;
    post(5'b10111, MEM);
    `CHK("grants", 5'b10101, gnt)
    step;
    `CHK("mem load", 2'h3, load)
    #1;
    `CHK("held grant", 5'b00010, gnt)
    step;
    `CHK("mem load", 2'h1, load)
  endtask

  // Same peripheral and same memory port: the accelerator always wins.
  task t_conflict(input logic [4:0] m, input logic [31:0] a, input logic [4:0] nxt);
    post(m, a);
    `CHK("winner", 5'b10000, gnt)
    step;
    #1;
    `CHK("loser", nxt, gnt)
    step;
  endtask

  // Accelerator on a peripheral beside the host on memory, then two
  // core ports queue for the peripheral in fixed order.
  task t_chain;
    i_xbpa_masters.post(5'b10110, PER);
    post(5'b01000, MEM);
    `CHK("split", 5'b11000, gnt)
    step;
    #1;
    `CHK("dp0 next", 5'b00100, gnt)
    step;
    #1;
    `CHK("dp1 last", 5'b00010, gnt)
    step;
    `CHK("per busy", 1'b1, pbusy)
  endtask

  // A refused host request gives no grant and one error per held cycle.
  task t_host_ref(input logic [31:0] a);
    post(5'b01000, a);
    `CHK("host grant", 1'b0, gnt[3])
    step;
    `CHK("host err", 1'b1, herr)
    i_xbpa_masters.drop(5'b01000);
    step;
    `CHK("host err", 1'b0, herr)
  endtask

  // Host page limit on and off, with a lone core access at the end.
  task t_page;
    i_xbpa_masters.set_page(1'b1, 16'h1234);
    step;
    post(5'b01000, 32'h1234_0010);
    `CHK("in page", 5'b01000, gnt)
    step;
    t_host_ref(32'h1235_0000);
    i_xbpa_masters.set_page(1'b0, 16'h1234);
    step;
    post(5'b01000, 32'h1235_0000);
    `CHK("page off", 5'b01000, gnt)
    step;
    post(5'b00100, MEM);
    `CHK("lone dp0", 5'b00100, gnt)
    step;
    `CHK("mem load", 2'h1, load)
  endtask

  // Prints the counts and the verdict, then ends the run.
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence: reset for 4 cycles, then each scenario in turn.
  initial
  begin
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    `CHK("err after reset", 1'b0, herr)
    step;
    t_parallel;
    t_mem_four;
    t_conflict(5'b10100, PER, 5'b00100);
    `CHK("per busy", 1'b1, pbusy)
    t_conflict(5'b11000, MEM, 5'b01000);
    t_chain;
    t_host_ref(PER);
    t_page;
    end_sim;
  end

  // The scenarios take about 26 cycles; 400 means a hang.
  initial
  begin
    #3200;
    bad_count++;
    end_sim;
  end
endmodule // crossbar_priority_arbiter_test
`default_nettype wire

// >>> bench/xbpa_masters.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Bus masters on the far side: accelerator, host port and core.
// ----------------------------------------------------------------
module xbpa_masters
(
  // Clock and grants; bit 4 down to 0 is acc, host, dp0, dp1, fetch.
  input  wire logic             ref_clk_in,
  input  wire logic [4:0]       gnt_in,
  // Requests and their addresses.
  output logic      [4:0]       req_out,
  output logic      [4:0][31:0] addr_out,
  // Host page control, reachable from the core side only.
  output logic                  page_wr_out,
  output logic                  page_en_out,
  output logic      [15:0]      page_base_out
);
  // Everything starts idle so no request precedes reset release.
  initial
  begin
    req_out = '0;
    addr_out = '0;
    page_wr_out = 1'b0;
    page_en_out = 1'b0;
    page_base_out = '0;
  end

  // A request stands until the edge that grants it; the address is then
  // inverted so that a stale value can never pass for a live one.
  // Retiring on the edge itself keeps every later bench move at one delay.
  always @(posedge ref_clk_in)
  begin
    for (int m = 0; m < 5; m++)
      if (req_out[m] && gnt_in[m])
      begin
        req_out[m]  <= 1'b0;
        addr_out[m] <= ~addr_out[m];
      end
  end

  // Raises the chosen requests, all with the same address.
  task post(input logic [4:0] m, input logic [31:0] a);
    req_out |= m;
    for (int i = 0; i < 5; i++)
      if (m[i]) addr_out[i] = a;
  endtask

  // Withdraws a refused request, which would otherwise never end.
  task drop(input logic [4:0] m);
    req_out &= ~m;
  endtask

  // Only the core writes the host page, so the host has no path here.
  task set_page(input logic en, input logic [15:0] base);
    page_wr_out = 1'b1;
    page_en_out = en;
    page_base_out = base;
    @(posedge ref_clk_in);
    #1;
    page_wr_out = 1'b0;
  endtask
endmodule // xbpa_masters
`default_nettype wire

// >>> design/xbpa_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
module xbpa_arbiter
  import xbpa_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Data movement accelerator master.
  input  wire logic        acc_req_in,
  input  wire logic [31:0] acc_addr_in,
  output logic             acc_gnt_out,
  // External host port master.
  input  wire logic        hst_req_in,
  input  wire logic [31:0] hst_addr_in,
  output logic             hst_gnt_out,
  output logic             hst_err_out,
  // Core data ports and instruction fetch port.
  input  wire logic        dp0_req_in,
  input  wire logic [31:0] dp0_addr_in,
  output logic             dp0_gnt_out,
  input  wire logic        dp1_req_in,
  input  wire logic [31:0] dp1_addr_in,
  output logic             dp1_gnt_out,
  input  wire logic        fetch_req_in,
  output logic             fetch_gnt_out,
  // Host page control, written by the core only.
  input  wire logic        core_page_wr_in,
  input  wire logic        core_page_en_in,
  input  wire logic [15:0] core_page_base_in,
  // Status.
  output logic [1:0]       mem_load_out,
  output logic             per_busy_out
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Used for every master that has an address, so it lives in one place.
  function automatic logic is_per(input logic [31:0] a);
    is_per = (a[PER_SEL_HI:PER_SEL_LO] == PER_SEL_VAL);
  endfunction

  logic acc_per;   // Accelerator wants the peripheral target.
  logic acc_mem;   // Accelerator wants memory.
  logic dp0_per;   // Data port 0 wants the peripheral target.
  logic dp0_mem;   // Data port 0 wants memory.
  logic dp1_per;   // Data port 1 wants the peripheral target.
  logic dp1_mem;   // Data port 1 wants memory.
  logic hst_ok;    // Host request that may proceed at all.
  logic hst_bad;   // Host request that must be refused.
  logic in_page;   // Host address lies inside the allowed page.

  // ----------------------------------------------------------------
  // Host page registers
  // ----------------------------------------------------------------

  logic        page_en;        // Page limit active.
  logic [15:0] page_base;      // Upper address bits of the page.
  logic        next_page_en;   // Next page limit.
  logic [15:0] next_page_base; // Next page base.

  // The host has no path to these; only the core strobe loads them.
  always_comb
  begin
    next_page_en   = page_en;
    next_page_base = page_base;
    if (core_page_wr_in)
    begin
      next_page_en   = core_page_en_in;
      next_page_base = core_page_base_in;
    end
  end

  // Registers the page state.
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      // Reset leaves the host free to reach every non-peripheral address.
      page_en   <= PAGE_EN_RST;
      page_base <= PAGE_RST;
    end
    else
    begin
      // Only the core strobe can have changed the next values.
      page_en   <= next_page_en;
      page_base <= next_page_base;
    end
  end

  // ----------------------------------------------------------------
  // Request classification
  // ----------------------------------------------------------------

  // The accelerator and both data ports are steered to one target by their address.
  always_comb
  begin
    acc_per = acc_req_in & is_per(acc_addr_in);
    acc_mem = acc_req_in & ~is_per(acc_addr_in);
    dp0_per = dp0_req_in & is_per(dp0_addr_in);
    dp0_mem = dp0_req_in & ~is_per(dp0_addr_in);
    dp1_per = dp1_req_in & is_per(dp1_addr_in);
    dp1_mem = dp1_req_in & ~is_per(dp1_addr_in);
    // Outside the page is refused while the limit is on.
    in_page = ~page_en | (hst_addr_in[31:PAGE_LO] == page_base);
    // No host path to peripherals exists.
    hst_ok  = hst_req_in & in_page & ~is_per(hst_addr_in);
    hst_bad = hst_req_in & ~hst_ok;
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------

  logic pp_req;   // Peripheral-side memory port requested.
  logic pp_acc;   // That port is used by the accelerator.
  logic g_pp;     // Peripheral-side memory port granted.
  logic g_fetch;  // Fetch port granted.
  logic g_dm0;    // Data port 0 granted to memory.
  logic g_dm1;    // Data port 1 granted to memory.
  logic g_pacc;   // Accelerator granted the peripheral target.
  logic g_pd0;    // Data port 0 granted the peripheral target.
  logic g_pd1;    // Data port 1 granted the peripheral target.

  // Grants are combinational so that an uncontested access is
  // taken at the very edge where it is presented. Two targets are
  // arbitrated independently, so no master waits on another target.
  always_comb
  begin
    // One 32-bit port for the peripheral side; accelerator wins.
    pp_req  = acc_mem | hst_ok;
    pp_acc  = acc_mem;
    // Memory: port order pp, fetch, dp0, dp1; three slots only.
    g_pp    = pp_req;
    g_fetch = fetch_req_in;
    g_dm0   = dp0_mem;
    // The fourth source waits when the other three are busy.
    g_dm1   = dp1_mem & ~(pp_req & fetch_req_in & dp0_mem);
    // Peripheral target: fixed order, accelerator above core.
    g_pacc  = acc_per;
    g_pd0   = dp0_per & ~acc_per;
    g_pd1   = dp1_per & ~acc_per & ~dp0_per;
  end

  // Losers see their grant low and keep their request up.
  // The order never rotates, so a higher master that asks every cycle
  // starves the lower ones; the system has to pace its traffic.
  assign acc_gnt_out   = g_pacc | (g_pp & pp_acc);
  assign hst_gnt_out   = g_pp & ~pp_acc;
  assign dp0_gnt_out   = g_dm0 | g_pd0;
  assign dp1_gnt_out   = g_dm1 | g_pd1;
  assign fetch_gnt_out = g_fetch;

  // ----------------------------------------------------------------
  // Status registers
  // ----------------------------------------------------------------

  logic [1:0] mem_load;       // Memory accesses in the last cycle.
  logic       per_busy;       // Peripheral target used last cycle.
  logic       hst_err;        // Host refusal, one-cycle pulse.
  logic [1:0] next_mem_load;  // Next memory load.
  logic       next_per_busy;  // Next peripheral use.
  logic       next_hst_err;   // Next refusal pulse.
  logic [2:0] cnt;            // Sum of memory grants.

  // A refused host access shows once, a cycle later; the host is
  // expected to drop or retarget it, otherwise it repeats.
  always_comb
  begin
    cnt = {2'h0, g_pp} + {2'h0, g_fetch} + {2'h0, g_dm0} + {2'h0, g_dm1};
    next_mem_load = cnt[1:0];
    next_per_busy = g_pacc | g_pd0 | g_pd1;
    next_hst_err  = hst_bad;
  end

  // Registers the status.
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      // No traffic has been seen yet.
      mem_load <= LOAD_RST;
      per_busy <= BUSY_RST;
      hst_err  <= ERR_RST;
    end
    else
    begin
      // Record what was granted at this edge.
      mem_load <= next_mem_load;
      per_busy <= next_per_busy;
      hst_err  <= next_hst_err;
    end
  end

  assign mem_load_out = mem_load;
  assign per_busy_out = per_busy;
  assign hst_err_out  = hst_err;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // Accelerator on peripherals and host on memory at once.
  sequence s_split;
    acc_per && hst_ok;
  endsequence

  // Data port 1 loses the peripheral target to a higher master.
  sequence s_lost;
    dp1_per && (acc_per || dp0_per);
  endsequence

  // A refused host request: no grant now, the error flag next cycle.
  sequence s_refused;
    !hst_gnt_out ##1 hst_err_out;
  endsequence

  a_parallel_targets: assert property (
    s_split |-> (acc_gnt_out && hst_gnt_out))
    else $error("parallel targets were serialised");

  a_fixed_prio: assert property (
    (dp0_per && dp1_per && !acc_per) |-> (dp0_gnt_out && !dp1_gnt_out))
    else $error("peripheral order broken");

  a_accel_first: assert property (
    (acc_mem && hst_req_in) |-> (acc_gnt_out && !hst_gnt_out))
    else $error("accelerator did not win the memory port");

  a_host_no_periph: assert property (
    (hst_req_in && is_per(hst_addr_in)) |-> s_refused)
    else $error("host reached a peripheral");

  a_mem_three: assert property (
    ##1 ({1'b0, mem_load_out} == $past(cnt)) && (cnt <= MEM_SLOTS))
    else $error("memory slot count exceeded");

  a_core_ports: assert property (
    (fetch_req_in && dp0_mem && dp1_mem && !pp_req)
      |-> (fetch_gnt_out && dp0_gnt_out && dp1_gnt_out))
    else $error("core ports not served together");

  a_port_single: assert property (
    !(acc_mem && hst_gnt_out))
    else $error("shared port used twice");

  a_single_cycle: assert property (
    (dp0_mem && !(pp_req && fetch_req_in && dp1_mem)) |-> dp0_gnt_out)
    else $error("core data access delayed");

  a_page_limit: assert property (
    (hst_req_in && page_en && hst_addr_in[31:PAGE_LO] != page_base)
      |-> s_refused)
    else $error("host left its page");

  a_page_core_only: assert property (
    !core_page_wr_in |=> ($stable(page_base) && $stable(page_en)))
    else $error("page changed without core write");

  a_wait_hold: assert property (
    s_lost |-> !dp1_gnt_out)
    else $error("loser granted");

  // The fetch port always finds a free memory slot.
  a_fetch_served: assert property (
    fetch_req_in |-> fetch_gnt_out)
    else $error("fetch request not served");

  // Any peripheral request wins for someone and shows a cycle later.
  a_per_status: assert property (
    (acc_per || dp0_per || dp1_per) |=> per_busy_out)
    else $error("peripheral use not reported");

  // The error flag only ever follows a host request.
  a_err_source: assert property (
    hst_err_out |-> $past(hst_req_in))
    else $error("host error without request");

  // A lawful host request gets the shared port when the accelerator is away.
  a_host_served: assert property (
    (hst_ok && !acc_mem) |-> hst_gnt_out)
    else $error("host not served on a free port");

  // No grant is ever given to a master that is not asking.
  a_no_spurious: assert property (
    !(acc_gnt_out && !acc_req_in) && !(hst_gnt_out && !hst_req_in)
      && !(dp0_gnt_out && !dp0_req_in) && !(dp1_gnt_out && !dp1_req_in))
    else $error("grant without request");

endmodule // xbpa_arbiter
`default_nettype wire

// >>> pkg/xbpa_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// Shared constants of the crossbar arbiter.
// ----------------------------------------------------------------
package xbpa_pkg;
  // Address bits that pick the peripheral target.
  localparam int          PER_SEL_HI  = 31;
  localparam int          PER_SEL_LO  = 28;
  localparam logic [3:0]  PER_SEL_VAL = 4'h4;
  // Host page: 64K bytes, so the page is named by bits 31:16.
  localparam int          PAGE_LO     = 16;
  localparam logic [15:0] PAGE_RST    = 16'h0000;
  localparam logic        PAGE_EN_RST = 1'b0;
  // Widths of the memory request sources.
  localparam int          DP_W        = 64;
  localparam int          FETCH_W     = 256;
  localparam int          PP_W        = 32;
  // The memory controller serves at most this many at once.
  localparam logic [2:0]  MEM_SLOTS   = 3'h3;
  // Status outputs after reset.
  localparam logic [1:0]  LOAD_RST    = 2'h0;
  localparam logic        BUSY_RST    = 1'b0;
  localparam logic        ERR_RST     = 1'b0;
endpackage : xbpa_pkg
`default_nettype wire
